// file: rtl/gsl_cfg.svh
`ifndef GSL_CFG_SVH
`define GSL_CFG_SVH

// register byte offsets
`define GSL_OFS_CFG        32'h0000_0000
`define GSL_OFS_DOUT       32'h0000_0004
`define GSL_OFS_PINS       32'h0000_0008
`define GSL_OFS_STAT       32'h0000_000c

// pin configuration fields
`define GSL_CFG_MODE_LSB   0
`define GSL_CFG_LAMP_LSB   8
`define GSL_MODE_RESET     6'h00
`define GSL_LAMP_RESET     3'h0
`define GSL_DOUT_RESET     3'h0

// per-pin mode codes, code 3 behaves as input
`define GSL_MODE_IN        2'h0
`define GSL_MODE_PUSH      2'h1
`define GSL_MODE_OD        2'h2

// status fields
`define GSL_STAT_LAMP_LSB  0
`define GSL_STAT_LINK      4
`define GSL_STAT_SPD100    5
`define GSL_STAT_FDX       6
`define GSL_STAT_ANEG      7

// bus responses
`define GSL_RESP_OKAY      2'h0
`define GSL_RESP_SLVERR    2'h2

// activity lamp timing
`define GSL_CLK_MHZ        100
`define GSL_LAMP_MS        80
`define GSL_LAMP_CYCLES    (`GSL_LAMP_MS * 1000 * `GSL_CLK_MHZ)

`endif

// file: rtl/gsl_pkg.sv
package gsl_pkg;

	typedef enum logic [1:0] {
		bl_lit,
		bl_dark,
		bl_hold
	} gsl_blink_st_t;

	typedef enum logic [2:0] {
		reg_cfg,
		reg_dout,
		reg_pins,
		reg_stat,
		reg_none
	} gsl_reg_t;

endpackage

// file: rtl/gsl_blink.sv
`timescale 1ns/1ns
`include "gsl_cfg.svh"

module gsl_blink #(
	parameter int PULSE_CYCLES = `GSL_LAMP_CYCLES,
	parameter int CNT_W        = 24
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic link_up,
	input  wire logic activity,
	output logic      lamp_n
);
	import gsl_pkg::*;

	typedef struct packed {
		gsl_pkg::gsl_blink_st_t st;
		logic [CNT_W-1:0]       cnt;
		logic                   pend;
		logic                   lamp_n;
	} gsl_blink_t;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(PULSE_CYCLES - 1);

	gsl_blink_t r;
	gsl_blink_t next_r;

	if (PULSE_CYCLES < 1 || PULSE_CYCLES > (2 ** CNT_W)) begin : g_bad
		$error("pulse length does not fit the counter");
	end

	always_comb begin
		next_r = r;
		// activity seen while dark or holding waits for the next flash
		if (activity) begin
			next_r.pend = 1'b1;
		end
		case (r.st)
		bl_lit: begin
			next_r.lamp_n = 1'b0;
			if (r.pend || activity) begin
				next_r.st     = bl_dark;
				next_r.cnt    = '0;
				next_r.pend   = 1'b0;
				next_r.lamp_n = 1'b1;
			end
		end
		bl_dark: begin
			if (r.cnt == LAST) begin
				next_r.st     = bl_hold;
				next_r.cnt    = '0;
				next_r.lamp_n = 1'b0;
			end else begin
				next_r.cnt = r.cnt + 1'b1;
			end
		end
		bl_hold: begin
			if (r.cnt == LAST) begin
				next_r.st  = bl_lit;
				next_r.cnt = '0;
			end else begin
				next_r.cnt = r.cnt + 1'b1;
			end
		end
		default: begin
			next_r.st = bl_lit;
		end
		endcase
		// no link: lamp dark, timing restarts on the next link
		if (!link_up) begin
			next_r.st     = bl_lit;
			next_r.cnt    = '0;
			next_r.pend   = 1'b0;
			next_r.lamp_n = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r.st     <= bl_lit;
			r.cnt    <= '0;
			r.pend   <= 1'b0;
			r.lamp_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign lamp_n = r.lamp_n;

endmodule

// file: rtl/gsl_lamp_port.sv
`timescale 1ns/1ns
`include "gsl_cfg.svh"

// Operation
// - each pin is push-pull output, open-drain output or input per config
// - each pin may instead carry its status lamp
// - a lamp pin only pulls low or releases, never drives high
// - speed lamp high only in 10 Mb/s operation, else low
// - link/activity lamp lit low on valid link, steady without traffic
// - activity makes the link/activity lamp go dark for 80 ms
// - then lit at least 80 ms before another dark pulse on activity

module gsl_lamp_port #(
	parameter int ADDR_W       = 8,
	parameter int PULSE_CYCLES = `GSL_LAMP_CYCLES,
	parameter int CNT_W        = 24
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        link_up,
	input  wire logic        speed_100,
	input  wire logic        autoneg_busy,
	input  wire logic        full_duplex,
	input  wire logic        tx_activity,
	input  wire logic        rx_activity,
	input  wire logic [2:0]  gpio_in,
	output logic [2:0]       gpio_out,
	output logic [2:0]       gpio_oe,
	output logic [2:0]       status_lamp_outputs
);
	import gsl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              aw_have;
		logic              w_have;
		logic [ADDR_W-1:0] waddr;
		logic [31:0]       wdat;
		logic [3:0]        wstb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [5:0]        mode;
		logic [2:0]        lamp_en;
		logic [2:0]        dout;
		logic [2:0]        pins_in;
		logic [2:0]        lamps_n;
		logic [2:0]        pin_out;
		logic [2:0]        pin_oe;
	} gsl_state_t;

	gsl_state_t r;
	gsl_state_t next_r;
	logic       act_lamp_n;
	logic [2:0] drv_out;
	logic [2:0] drv_oe;

	if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad
		$error("address width must be 4 to 32 bits");
	end

	////////////////////////////////////////////////////////////////////////
	// address decode, shared by both channels

	function automatic gsl_reg_t decode(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] a;
		a = {addr[ADDR_W-1:2], 2'b00};
		if (a == ADDR_W'(`GSL_OFS_CFG)) begin
			decode = reg_cfg;
		end else if (a == ADDR_W'(`GSL_OFS_DOUT)) begin
			decode = reg_dout;
		end else if (a == ADDR_W'(`GSL_OFS_PINS)) begin
			decode = reg_pins;
		end else if (a == ADDR_W'(`GSL_OFS_STAT)) begin
			decode = reg_stat;
		end else begin
			decode = reg_none;
		end
	endfunction

	function automatic logic [31:0] read_word(input gsl_reg_t sel,
		input gsl_state_t s, input logic [3:0] live);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (sel)
		reg_cfg: begin
			w = (32'(s.mode) << `GSL_CFG_MODE_LSB)
				| (32'(s.lamp_en) << `GSL_CFG_LAMP_LSB);
		end
		reg_dout: begin
			w = 32'(s.dout);
		end
		reg_pins: begin
			w = 32'(s.pins_in);
		end
		reg_stat: begin
			w = 32'(s.lamps_n) << `GSL_STAT_LAMP_LSB;
			w[`GSL_STAT_LINK]   = live[0];
			w[`GSL_STAT_SPD100] = live[1];
			w[`GSL_STAT_FDX]    = live[2];
			w[`GSL_STAT_ANEG]   = live[3];
		end
		default: begin
			w = 32'h0000_0000;
		end
		endcase
		read_word = w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// activity lamp timing

	gsl_blink #(
		.PULSE_CYCLES (PULSE_CYCLES),
		.CNT_W        (CNT_W)
	) u_blink (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.link_up  (link_up),
		.activity (tx_activity | rx_activity),
		.lamp_n   (act_lamp_n)
	);

	////////////////////////////////////////////////////////////////////////
	// pin drivers

	for (genvar i = 0; i < 3; i++) begin : g_pin
		always_comb begin
			drv_out[i] = 1'b0;
			drv_oe[i]  = 1'b0;
			if (r.lamp_en[i]) begin
				// lamp pins only sink current
				drv_out[i] = 1'b0;
				drv_oe[i]  = ~r.lamps_n[i];
			end else begin
				case (r.mode[2*i +: 2])
				`GSL_MODE_PUSH: begin
					drv_out[i] = r.dout[i];
					drv_oe[i]  = 1'b1;
				end
				`GSL_MODE_OD: begin
					drv_out[i] = 1'b0;
					drv_oe[i]  = ~r.dout[i];
				end
				default: begin
					drv_out[i] = 1'b0;
					drv_oe[i]  = 1'b0;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_r = r;

		// lamps: speed lamp dark only in a settled 10 Mb/s link
		next_r.lamps_n[0] = link_up & ~speed_100 & ~autoneg_busy;
		next_r.lamps_n[1] = act_lamp_n;
		next_r.lamps_n[2] = ~(link_up & full_duplex);
		next_r.pin_out    = drv_out;
		next_r.pin_oe     = drv_oe;
		next_r.pins_in    = gpio_in;

		// write response taken
		if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
		end

		// address and data arrive in either order
		if (s_axi_awvalid && r.awready) begin
			next_r.aw_have = 1'b1;
			next_r.waddr   = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready) begin
			next_r.w_have = 1'b1;
			next_r.wdat   = s_axi_wdata;
			next_r.wstb   = s_axi_wstrb;
		end

		// perform the write once both halves are held
		if (r.aw_have && r.w_have && !r.bvalid) begin
			next_r.aw_have = 1'b0;
			next_r.w_have  = 1'b0;
			next_r.bvalid  = 1'b1;
			next_r.bresp   = `GSL_RESP_OKAY;
			case (decode(r.waddr))
			reg_cfg: begin
				if (r.wstb[0]) begin
					next_r.mode = r.wdat[`GSL_CFG_MODE_LSB +: 6];
				end
				if (r.wstb[1]) begin
					next_r.lamp_en = r.wdat[`GSL_CFG_LAMP_LSB +: 3];
				end
			end
			reg_dout: begin
				if (r.wstb[0]) begin
					next_r.dout = r.wdat[2:0];
				end
			end
			reg_pins, reg_stat: begin
				// read-only, write ignored
				next_r.bresp = `GSL_RESP_OKAY;
			end
			default: begin
				next_r.bresp = `GSL_RESP_SLVERR;
			end
			endcase
		end
		// one write in flight: no new halves until the response is taken
		next_r.awready = ~next_r.aw_have & ~next_r.bvalid;
		next_r.wready  = ~next_r.w_have & ~next_r.bvalid;

		// read channel
		if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r.arready) begin
			next_r.rvalid = 1'b1;
			next_r.rdata  = read_word(decode(s_axi_araddr), r,
				{autoneg_busy, full_duplex, speed_100, link_up});
			next_r.rresp  = (decode(s_axi_araddr) == reg_none)
				? `GSL_RESP_SLVERR : `GSL_RESP_OKAY;
		end
		next_r.arready = ~next_r.rvalid;
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r.awready <= 1'b0;
			r.wready  <= 1'b0;
			r.aw_have <= 1'b0;
			r.w_have  <= 1'b0;
			r.waddr   <= '0;
			r.wdat    <= 32'h0000_0000;
			r.wstb    <= 4'h0;
			r.bvalid  <= 1'b0;
			r.bresp   <= `GSL_RESP_OKAY;
			r.arready <= 1'b0;
			r.rvalid  <= 1'b0;
			r.rdata   <= 32'h0000_0000;
			r.rresp   <= `GSL_RESP_OKAY;
			r.mode    <= `GSL_MODE_RESET;
			r.lamp_en <= `GSL_LAMP_RESET;
			r.dout    <= `GSL_DOUT_RESET;
			r.pins_in <= 3'h0;
			r.lamps_n <= 3'h7;
			r.pin_out <= 3'h0;
			r.pin_oe  <= 3'h0;
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from flops

	assign s_axi_awready       = r.awready;
	assign s_axi_wready        = r.wready;
	assign s_axi_bresp         = r.bresp;
	assign s_axi_bvalid        = r.bvalid;
	assign s_axi_arready       = r.arready;
	assign s_axi_rdata         = r.rdata;
	assign s_axi_rresp         = r.rresp;
	assign s_axi_rvalid        = r.rvalid;
	assign gpio_out            = r.pin_out;
	assign gpio_oe             = r.pin_oe;
	assign status_lamp_outputs = r.lamps_n;

endmodule

// file: tb/gsl_lamp_port_asserts.sv
`timescale 1ns/1ns
module gsl_lamp_chk #(
	parameter int PULSE_CYCLES = 4
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        link_up,
	input wire logic        speed_100,
	input wire logic        autoneg_busy,
	input wire logic        full_duplex,
	input wire logic [2:0]  status_lamp_outputs
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	// run lengths of the link/activity lamp; ok flags drop any period
	// touched by link loss, so only genuine flashes are timed
	logic [23:0] dk;
	logic [23:0] lt;
	logic        dok;
	logic        lok;
	logic        d;
	assign d = status_lamp_outputs[1];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dk <= '0;
			lt <= '0;
			dok <= 1'b0;
			lok <= 1'b0;
		end else begin
			dk <= d ? dk + 24'h1 : 24'h0;
			lt <= d ? 24'h0 : lt + 24'h1;
			dok <= d ? dok & link_up : link_up;
			lok <= d ? dok : lok & link_up;
		end
	end
	////////////////////////////////////////////////////////////////////////
	spd_lamp_a: assert property ($past(aresetn) && $past(aresetn, 2) |->
		status_lamp_outputs[0] == $past(link_up && !speed_100 && !autoneg_busy))
		else $error("speed lamp wrong");
	dpx_lamp_a: assert property ($past(aresetn) && $past(aresetn, 2) |->
		status_lamp_outputs[2] == !$past(link_up && full_duplex))
		else $error("duplex lamp wrong");
	link_off_a: assert property (!link_up [*3] |=> d)
		else $error("lamp lit without link");
	dark_len_a: assert property ($fell(d) && dok && link_up |->
		dk == PULSE_CYCLES) else $error("dark pulse length wrong");
	lit_hold_a: assert property ($rose(d) && lok |->
		lt >= PULSE_CYCLES) else $error("lit gap too short");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	r_hold_a: assert property (s_axi_rvalid && !$past(s_axi_arready) |->
		$stable(s_axi_rdata)) else $error("rdata changed");
	r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	w_lat_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
endmodule

bind gsl_lamp_port gsl_lamp_chk #(.PULSE_CYCLES(PULSE_CYCLES)) gsl_lamp_chk_i (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .link_up,
	.speed_100, .autoneg_busy, .full_duplex, .status_lamp_outputs);

// file: tb/gsl_pins_model.sv
`timescale 1ns/1ns
module gsl_pins_model (
	input  wire logic [2:0] gpio_out,
	input  wire logic [2:0] gpio_oe,
	input  wire logic [2:0] ext_oe,
	input  wire logic [2:0] ext_val,
	output logic [2:0]      pin
);
	// board pull-ups: a released pin rises, it never keeps its old level
	assign pin = (gpio_oe & gpio_out) | (~gpio_oe & ext_oe & ext_val)
		| (~gpio_oe & ~ext_oe);
endmodule

// file: tb/tb_gsl_lamp_port.sv
`timescale 1ns/1ns
module tb_gsl_lamp_port;
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'd27446;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        link_up = 0, speed_100 = 0, autoneg_busy = 0;
	logic        full_duplex = 0, tx_activity = 0, rx_activity = 0;
	logic [2:0]  gin, gpio_out, gpio_oe, status_lamp_outputs;
	logic [2:0]  ext_oe = '0, ext_val = '0;
	logic [33:0] exp_q[$];
	logic        slow = 1'b0;
	int          failures = 0, cmp_count = 0, cyc = 0;
	gsl_lamp_port #(.PULSE_CYCLES(4)) gsl_lamp_port_i (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_up, .speed_100,
		.autoneg_busy, .full_duplex, .tx_activity, .rx_activity,
		.gpio_in(gin), .gpio_out, .gpio_oe, .status_lamp_outputs);
	gsl_pins_model gsl_pins_model_i (.gpio_out, .gpio_oe, .ext_oe, .ext_val,
		.pin(gin));
	always #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic print_verdict();
		$display("failures=%0d comparisons=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [33:0] e, input logic [33:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// waits stay open-ended; the cycle ceiling below cuts any hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		exp_q.push_back({r, 32'h0});
		slow = ~slow;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= ~slow;
		fork
			begin
				do @(negedge aclk); while (!s_axi_awready);
				@(posedge aclk);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(negedge aclk); while (!s_axi_wready);
				@(posedge aclk);
				s_axi_wvalid <= 1'b0;
			end
		join
		// every other access takes its response late, so held responses get checked
		if (slow) begin
			repeat (2) @(posedge aclk);
			s_axi_bready <= 1'b1;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge aclk);
		exp_q.push_back(e);
		slow = ~slow;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= ~slow;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		if (slow) begin
			@(posedge aclk);
			s_axi_rready <= 1'b1;
		end
		do @(negedge aclk); while (!s_axi_rvalid);
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (s_axi_rvalid && s_axi_rready) cmp(exp_q.pop_front(),
			{s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready) cmp(exp_q.pop_front(),
			{s_axi_bresp, 32'h0});
		if (cyc > 20000) begin
			failures++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] v;
		logic [7:0]  e;
		logic [2:0]  pe;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 34'h0);
		rd(8'h04, 34'h0);
		rd(8'h10, {2'h2, 32'h0});
		wr(8'h10, 32'hffff_ffff, 2'h2);
		wr(8'h08, 32'h0, 2'h0);
		rd(8'h08, {2'h0, 32'h7});
		for (int m = 0; m < 4; m++) begin
			v = rnd();
			wr(8'h00, {26'h0, m[1:0], m[1:0], m[1:0]}, 2'h0);
			wr(8'h04, {29'h0, v[2:0]}, 2'h0);
			pe = (m == 1) ? 3'h7 : (m == 2) ? ~v[2:0] : 3'h0;
			ext_oe <= (m == 1 || m == 2) ? 3'h0 : 3'h7;
			ext_val <= ~v[2:0];
			repeat (3) @(posedge aclk);
			rd(8'h08, {31'h0, (m == 1 || m == 2) ? v[2:0] : ~v[2:0]});
			cmp({31'h0, pe}, {31'h0, gpio_oe});
		end
		ext_oe <= 3'h0;
		wr(8'h00, 32'h700, 2'h0);
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			@(posedge aclk);
			{link_up, speed_100, autoneg_busy, full_duplex} <= v[3:0];
			repeat (4) @(posedge aclk);
			e = {v[1], v[0], v[2], v[3], 1'b0, ~(v[3] & v[0]), ~v[3],
				v[3] & ~v[2] & ~v[1]};
			rd(8'h0c, {26'h0, e});
			rd(8'h08, {31'h0, e[2:0]});
			cmp(34'h0, {31'h0, gpio_oe & gpio_out});
		end
		@(posedge aclk);
		{link_up, speed_100, autoneg_busy, full_duplex} <= 4'h8;
		repeat (6) @(posedge aclk);
		tx_activity <= 1'b1;
		@(posedge aclk);
		tx_activity <= 1'b0;
		repeat (20) @(posedge aclk);
		rx_activity <= 1'b1;
		repeat (40) @(posedge aclk);
		rx_activity <= 1'b0;
		repeat (30) @(posedge aclk);
		rd(8'h0c, {26'h0, 8'h15});
		print_verdict();
	end
endmodule
